// ### design/pio_pkg.sv
// Constants and types shared by the parallel port block
// Functional notes
// - Port 0 bits 0 and 7 are input-only, with no driver and no direction setting.
// - Every bidirectional pin outside port 4 has its own direction bit.
// - Port 4 switches all eight pins together from one direction setting.
// - A falling edge on any port 4 pin sets the port 4 edge test flag to 1.
// - Ports 1 to 5 apply their software pull-up only while the pin is an input.
// - Port 0 bits 1-6, port 6 bits 4-7 and ports 7, 12, 13 allow pull-up in either direction.
// - Port 6 bits 0-3 are open-drain: they pull low only, never drive high.
// - Port 6 bits 0-3 take their pull-up from a fixed mask option, not from software.
// - A timer or external interrupt request copies the real-time buffer into the port latch.
// - The port 4 edge source, gated by its mask flag, joins the watch timer overflow as test input.
package pio_pkg;
    localparam int NPORT = 10;
    typedef logic [NPORT-1:0][7:0] pio_bytes_t;
    // Port slot indices; ports 12 and 13 sit in slots 8 and 9
    localparam int IDX_P0 = 0;
    localparam int IDX_P4 = 4;
    localparam int IDX_P6 = 6;
    localparam int IDX_P12 = 8;
    localparam int RTO_PORT = IDX_P12;
    // Write selectors of the software write port
    localparam logic [1:0] SEL_LATCH = 2'h0;
    localparam logic [1:0] SEL_DIR = 2'h1;
    localparam logic [1:0] SEL_PU = 2'h2;
    localparam logic [1:0] SEL_RTOBUF = 2'h3;
    // Bits that exist as pins, per slot (P0..P7, P12, P13)
    localparam pio_bytes_t PRESENT_MASK = {8'h03, 8'hFF, 8'h07, 8'hFF, 8'hFF,
                                           8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam pio_bytes_t INPUT_ONLY_MASK = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                              8'h00, 8'h00, 8'h00, 8'h00, 8'h81};
    localparam pio_bytes_t OPEN_DRAIN_MASK = {8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
                                              8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam pio_bytes_t PU_IN_ONLY_MASK = {8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
                                              8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    localparam pio_bytes_t PU_ANY_MASK = {8'h03, 8'hFF, 8'h07, 8'hF0, 8'h00,
                                          8'h00, 8'h00, 8'h00, 8'h00, 8'h7E};
    localparam pio_bytes_t PU_FIXED_MASK = {8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
                                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // Mask option value of the fixed pull-ups on port 6 bits 0-3
    localparam logic [7:0] PU_FIXED_OPTION = 8'h0F;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PU_RST = 8'h00;
endpackage

// ### design/pio_wr_if.sv
// Software write and real-time transfer carrier to each port slot
`timescale 1ns/1ps
interface pio_wr_if;
    logic wr_en;
    logic [3:0] wr_port;
    logic [1:0] wr_sel;
    logic [7:0] wr_data;
    logic rto_fire;
    logic [7:0] rto_data;
    modport source (output wr_en, wr_port, wr_sel, wr_data, rto_fire, rto_data);
    modport sink (input wr_en, wr_port, wr_sel, wr_data, rto_fire, rto_data);
endinterface

// ### design/pio_port_bits.sv
// One port slot: output latch, direction, pull-up and pad drive
`timescale 1ns/1ps
module pio_port_bits #(
    parameter int IDX = 0
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Write carrier
    pio_wr_if.sink wr,
    // Pad side
    output logic [7:0] pad_out_o,
    output logic [7:0] pad_oe_o,
    output logic [7:0] pad_pu_o,
    // State for readback
    output logic [7:0] latch_o,
    output logic [7:0] dir_o
);
    import pio_pkg::*;

    localparam logic [7:0] PRES = PRESENT_MASK[IDX];
    localparam logic [7:0] INO = INPUT_ONLY_MASK[IDX];
    localparam logic [7:0] OD = OPEN_DRAIN_MASK[IDX];
    localparam logic [7:0] PUI = PU_IN_ONLY_MASK[IDX];
    localparam logic [7:0] PUA = PU_ANY_MASK[IDX];
    localparam logic [7:0] PUF = PU_FIXED_MASK[IDX];
    localparam logic [3:0] MY_PORT = 4'(IDX);

    logic [7:0] pu_sel;
    logic [7:0] next_latch;
    logic [7:0] next_dir;
    logic [7:0] next_pu_sel;
    logic hit;

    assign hit = wr.wr_en && (wr.wr_port == MY_PORT);

    always_comb
    begin
        next_latch = latch_o;
        if (IDX == RTO_PORT && wr.rto_fire)
        begin
            // Transfer beats a software latch write in the same cycle
            next_latch = wr.rto_data;
        end
        else if (hit && wr.wr_sel == SEL_LATCH)
        begin
            next_latch = wr.wr_data & PRES;
        end
    end

    always_comb
    begin
        next_dir = dir_o;
        if (hit && wr.wr_sel == SEL_DIR)
        begin
            if (IDX == IDX_P4)
            begin
                next_dir = {8{wr.wr_data[0]}};
            end
            else
            begin
                next_dir = wr.wr_data & PRES & ~INO;
            end
        end
    end

    always_comb
    begin
        next_pu_sel = pu_sel;
        if (hit && wr.wr_sel == SEL_PU)
        begin
            // Fixed pull-ups ignore software entirely
            next_pu_sel = wr.wr_data & (PUI | PUA);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            latch_o <= LATCH_RST;
            dir_o <= DIR_RST;
            pu_sel <= PU_RST;
        end
        else
        begin
            latch_o <= next_latch;
            dir_o <= next_dir;
            pu_sel <= next_pu_sel;
        end
    end

    // Pads are built from next state so they change on the same edge as the latch
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pad_out_o <= 8'h00;
            pad_oe_o <= 8'h00;
            pad_pu_o <= PUF & PU_FIXED_OPTION;
        end
        else
        begin
            pad_out_o <= next_latch & PRES & ~OD;
            pad_oe_o <= (next_dir & ~OD) | (next_dir & OD & ~next_latch);
            pad_pu_o <= (next_pu_sel & PUA)
                      | (next_pu_sel & PUI & ~next_dir)
                      | (PUF & PU_FIXED_OPTION);
        end
    end

    property p_inonly;
        @(posedge core_clk_i) disable iff (rst_i)
        1'b1 |-> ((pad_oe_o & INO) == 8'h00) && ((dir_o & INO) == 8'h00);
    endproperty
    a_inonly: assert property (p_inonly) else $error("input-only pin driven");

    property p_bytedir;
        @(posedge core_clk_i) disable iff (rst_i)
        (IDX == IDX_P4) |-> (dir_o == 8'h00 || dir_o == 8'hFF);
    endproperty
    a_bytedir: assert property (p_bytedir) else $error("port 4 direction split");

    property p_od;
        @(posedge core_clk_i) disable iff (rst_i)
        1'b1 |-> ((pad_out_o & OD) == 8'h00) && ((pad_oe_o & OD & latch_o) == 8'h00);
    endproperty
    a_od: assert property (p_od) else $error("open-drain pin driven high");

    property p_pufix;
        @(posedge core_clk_i) disable iff (rst_i)
        1'b1 |-> (pad_pu_o & PUF) == (PUF & PU_FIXED_OPTION);
    endproperty
    a_pufix: assert property (p_pufix) else $error("fixed pull-up changed");

    property p_puout;
        @(posedge core_clk_i) disable iff (rst_i)
        1'b1 |-> (pad_pu_o & PUI & dir_o) == 8'h00;
    endproperty
    a_puout: assert property (p_puout) else $error("pull-up on output pin");

    property p_puany;
        @(posedge core_clk_i) disable iff (rst_i)
        (hit && wr.wr_sel == SEL_PU) |=> ((pad_pu_o & PUA) == ($past(wr.wr_data) & PUA));
    endproperty
    a_puany: assert property (p_puany) else $error("pull-up write not applied");

    property p_dirbit;
        @(posedge core_clk_i) disable iff (rst_i)
        (hit && wr.wr_sel == SEL_DIR && IDX != IDX_P4)
            |=> dir_o == ($past(wr.wr_data) & PRES & ~INO);
    endproperty
    a_dirbit: assert property (p_dirbit) else $error("bit direction not applied");
endmodule

// ### design/pio_top.sv
// Parallel port block with edge test flag and real-time output transfer
`timescale 1ns/1ps
module pio_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Software write port
    input wire logic wr_en_i,
    input wire logic [3:0] wr_port_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic [7:0] wr_data_i,
    // Software read port
    input wire logic [3:0] rd_port_i,
    output logic [7:0] rd_data_o,
    // Real-time output triggers
    input wire logic rto_timer_req_i,
    input wire logic rto_ext_req_i,
    // Test function controls
    input wire logic edge_flag_clr_i,
    input wire logic edge_test_mask_i,
    input wire logic wt_ovf_i,
    input wire logic wt_flag_clr_i,
    input wire logic wt_test_mask_i,
    output logic port4_edge_test_flag_o,
    output logic wt_test_flag_o,
    output logic test_req_o,
    // Pads
    input wire pio_pkg::pio_bytes_t pad_in_i,
    output pio_pkg::pio_bytes_t pad_out_o,
    output pio_pkg::pio_bytes_t pad_oe_o,
    output pio_pkg::pio_bytes_t pad_pu_o
);
    import pio_pkg::*;

    pio_wr_if wr_bus ();
    pio_bytes_t latch;
    pio_bytes_t dir;
    logic [7:0] rto_buf;
    logic [7:0] p4_prev;
    logic rto_fire;
    logic port4_falling_edge_test_source;
    logic next_edge_flag;
    logic next_wt_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Write distribution and real-time transfer

    assign rto_fire = rto_timer_req_i | rto_ext_req_i;
    assign wr_bus.wr_en = wr_en_i;
    assign wr_bus.wr_port = wr_port_i;
    assign wr_bus.wr_sel = wr_sel_i;
    assign wr_bus.wr_data = wr_data_i;
    assign wr_bus.rto_fire = rto_fire;
    assign wr_bus.rto_data = rto_buf;

    // The buffer is preloaded by software ahead of the trigger; any slot number works
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rto_buf <= LATCH_RST;
        end
        else if (wr_en_i && wr_sel_i == SEL_RTOBUF)
        begin
            rto_buf <= wr_data_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++)
        begin : g_port
            pio_port_bits #(.IDX(g)) u_port (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .wr(wr_bus.sink),
                .pad_out_o(pad_out_o[g]),
                .pad_oe_o(pad_oe_o[g]),
                .pad_pu_o(pad_pu_o[g]),
                .latch_o(latch[g]),
                .dir_o(dir[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Readback: output pins show the latch, input pins show the pad

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_data_o <= 8'h00;
        end
        else if (rd_port_i < 4'(NPORT))
        begin
            rd_data_o <= ((latch[rd_port_i] & dir[rd_port_i])
                        | (pad_in_i[rd_port_i] & ~dir[rd_port_i])) & PRESENT_MASK[rd_port_i];
        end
        else
        begin
            rd_data_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port 4 falling edge and test flags

    // Previous sample resets low so a pin already low at release is not taken as an edge
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            p4_prev <= 8'h00;
        end
        else
        begin
            p4_prev <= pad_in_i[IDX_P4];
        end
    end

    assign port4_falling_edge_test_source = |(p4_prev & ~pad_in_i[IDX_P4]);

    // Set wins over a clear in the same cycle so no edge is lost
    assign next_edge_flag = port4_falling_edge_test_source
                          | (port4_edge_test_flag_o & ~edge_flag_clr_i);
    assign next_wt_flag = wt_ovf_i | (wt_test_flag_o & ~wt_flag_clr_i);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            port4_edge_test_flag_o <= 1'b0;
            wt_test_flag_o <= 1'b0;
        end
        else
        begin
            port4_edge_test_flag_o <= next_edge_flag;
            wt_test_flag_o <= next_wt_flag;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            test_req_o <= 1'b0;
        end
        else
        begin
            test_req_o <= (next_edge_flag & ~edge_test_mask_i)
                        | (next_wt_flag & ~wt_test_mask_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_rto;
        @(posedge core_clk_i) disable iff (rst_i)
        rto_fire |=> (latch[RTO_PORT] == $past(rto_buf)) && (pad_out_o[RTO_PORT] == $past(rto_buf));
    endproperty
    a_rto: assert property (p_rto) else $error("real-time transfer missed");

    property p_edge;
        @(posedge core_clk_i) disable iff (rst_i)
        (|(p4_prev & ~pad_in_i[IDX_P4])) |=> port4_edge_test_flag_o;
    endproperty
    a_edge: assert property (p_edge) else $error("falling edge did not set flag");

    property p_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        (port4_edge_test_flag_o && !edge_flag_clr_i) |=> port4_edge_test_flag_o;
    endproperty
    a_hold: assert property (p_hold) else $error("edge flag dropped without clear");

    property p_clr;
        @(posedge core_clk_i) disable iff (rst_i)
        (edge_flag_clr_i && !(|(p4_prev & ~pad_in_i[IDX_P4]))) |=> !port4_edge_test_flag_o;
    endproperty
    a_clr: assert property (p_clr) else $error("edge flag not cleared");

    property p_test;
        @(posedge core_clk_i) disable iff (rst_i)
        (port4_edge_test_flag_o && !edge_test_mask_i && !edge_flag_clr_i) |=> test_req_o;
    endproperty
    a_test: assert property (p_test) else $error("unmasked edge flag gave no test request");

    property p_testmask;
        @(posedge core_clk_i) disable iff (rst_i)
        (edge_test_mask_i && wt_test_mask_i) |=> !test_req_o;
    endproperty
    a_testmask: assert property (p_testmask) else $error("masked test request raised");

    // Input-only pins have no latch path, so readback always shows the pad
    property p_rdinonly;
        @(posedge core_clk_i) disable iff (rst_i)
        (rd_port_i == 4'(IDX_P0)) |=> ((rd_data_o & INPUT_ONLY_MASK[IDX_P0])
            == ($past(pad_in_i[IDX_P0]) & INPUT_ONLY_MASK[IDX_P0]));
    endproperty
    a_rdinonly: assert property (p_rdinonly) else $error("input-only pin misread");

    // One direction for the whole byte: readback is all latch or all pad
    property p_p4rd;
        @(posedge core_clk_i) disable iff (rst_i)
        (rd_port_i == 4'(IDX_P4)) |=> (rd_data_o == $past(latch[IDX_P4]))
            || (rd_data_o == $past(pad_in_i[IDX_P4]));
    endproperty
    a_p4rd: assert property (p_p4rd) else $error("port 4 read mixes directions");

    property p_srcreq;
        @(posedge core_clk_i) disable iff (rst_i)
        (port4_falling_edge_test_source && !edge_test_mask_i) |=> test_req_o;
    endproperty
    a_srcreq: assert property (p_srcreq) else $error("unmasked edge gave no test request");

    property p_wtreq;
        @(posedge core_clk_i) disable iff (rst_i)
        (wt_ovf_i && !wt_test_mask_i) |=> (wt_test_flag_o && test_req_o);
    endproperty
    a_wtreq: assert property (p_wtreq) else $error("watch overflow gave no test request");

    // Only a trigger or a software latch write may move the real-time latch
    property p_rtokeep;
        @(posedge core_clk_i) disable iff (rst_i)
        (!rto_fire && !(wr_en_i && wr_port_i == 4'(RTO_PORT) && wr_sel_i == SEL_LATCH))
            |=> $stable(latch[RTO_PORT]);
    endproperty
    a_rtokeep: assert property (p_rtokeep) else $error("real-time latch moved without cause");
endmodule

// ### sim/pio_pads_model.sv
// Board-side model of the port pads: loads, pull-ups and external drivers
`timescale 1ns/1ps
module pio_pads_model
    import pio_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Block side
    input wire pio_pkg::pio_bytes_t pad_out_i,
    input wire pio_pkg::pio_bytes_t pad_oe_i,
    input wire pio_pkg::pio_bytes_t pad_pu_i,
    // Board drivers
    input wire pio_pkg::pio_bytes_t ext_en_i,
    input wire pio_pkg::pio_bytes_t ext_val_i,
    output pio_pkg::pio_bytes_t pad_in_o
);
    // Starts known so a floating pad toggles instead of staying unknown
    pio_bytes_t float_q = '0;

    // An undriven, unpulled pad toggles so a stale value never reads back
    always @(posedge core_clk_i)
    begin
        float_q <= ~pad_in_o;
    end

    // Open-drain pads only ever reach this path with a low drive value
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                    | (~pad_oe_i & ~ext_en_i & pad_pu_i)
                    | (~pad_oe_i & ~ext_en_i & ~pad_pu_i & float_q);
endmodule

// ### sim/test_pio_top.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_pio_top;
    import pio_pkg::*;
    typedef struct {
        logic [3:0] port;
        logic [1:0] sel;
        logic [7:0] data;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] rd;
        logic [7:0] out;
    } pio_row_s;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_en = 1'b0;
    logic [3:0] wr_port = 4'h0;
    logic [1:0] wr_sel = 2'h0;
    logic [7:0] wr_data = 8'h00;
    logic [3:0] rd_port = 4'h0;
    logic [7:0] rd_data;
    logic tmr_req = 1'b0;
    logic ext_req = 1'b0;
    logic edge_clr = 1'b0;
    logic edge_mask = 1'b0;
    logic wt_ovf = 1'b0;
    logic wt_clr = 1'b0;
    logic wt_mask = 1'b0;
    logic edge_flag;
    logic wt_flag;
    logic test_req;
    pio_bytes_t pad_in;
    pio_bytes_t pad_out;
    pio_bytes_t pad_oe;
    pio_bytes_t pad_pu;
    pio_bytes_t ext_en = '0;
    pio_bytes_t ext_val = '0;
    int err_count = 0;
    int n_tests = 0;
    pio_row_s rows [14] = '{
        '{4'h1, SEL_PU, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{4'h1, SEL_DIR, 8'h0F, 8'h0F, 8'hF0, 8'hF0, 8'h00},
        '{4'h1, SEL_LATCH, 8'hA5, 8'h0F, 8'hF0, 8'hF5, 8'h05},
        '{4'h4, SEL_PU, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{4'h4, SEL_DIR, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00},
        '{4'h4, SEL_DIR, 8'hFE, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{4'h0, SEL_PU, 8'h7E, 8'h00, 8'h7E, 8'hFF, 8'h00},
        '{4'h0, SEL_DIR, 8'hFF, 8'h7E, 8'h7E, 8'h81, 8'h00},
        '{4'h6, SEL_PU, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{4'h6, SEL_DIR, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00},
        '{4'h6, SEL_LATCH, 8'h05, 8'hFA, 8'hFF, 8'h05, 8'h00},
        '{4'h8, SEL_PU, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00},
        '{4'h8, SEL_DIR, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00},
        '{4'h9, SEL_DIR, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00}
    };

    always #10 core_clk_i = ~core_clk_i;

    pio_top u_dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .wr_en_i(wr_en), .wr_port_i(wr_port), .wr_sel_i(wr_sel), .wr_data_i(wr_data),
        .rd_port_i(rd_port), .rd_data_o(rd_data),
        .rto_timer_req_i(tmr_req), .rto_ext_req_i(ext_req),
        .edge_flag_clr_i(edge_clr), .edge_test_mask_i(edge_mask),
        .wt_ovf_i(wt_ovf), .wt_flag_clr_i(wt_clr), .wt_test_mask_i(wt_mask),
        .port4_edge_test_flag_o(edge_flag), .wt_test_flag_o(wt_flag),
        .test_req_o(test_req),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pu_o(pad_pu)
    );

    pio_pads_model u_pads (
        .core_clk_i(core_clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .pad_pu_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One-cycle write; returns at the falling edge after the taking edge
    task automatic wr(input logic [3:0] port, input logic [1:0] sel, input logic [7:0] data);
        @(negedge core_clk_i);
        wr_en = 1'b1;
        wr_port = port;
        wr_sel = sel;
        wr_data = data;
        rd_port = port;
        @(negedge core_clk_i);
        wr_en = 1'b0;
    endtask

    task automatic pulse(ref logic sig);
        @(negedge core_clk_i);
        sig = 1'b1;
        @(negedge core_clk_i);
        sig = 1'b0;
    endtask

    initial
    begin
        #(20 * 2000);
        err_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        // Board holds the two input-only pins of port 0 at fixed levels
        ext_en[0] = 8'h81;
        ext_val[0] = 8'h81;
        repeat (20) @(negedge core_clk_i);
        rst_i = 1'b0;
        `CHK(pad_pu[6], PU_FIXED_OPTION)
        `CHK(pad_oe, pio_bytes_t'(0))
        `CHK({edge_flag, wt_flag, test_req}, 3'h0)
        foreach (rows[i])
        begin
            wr(rows[i].port, rows[i].sel, rows[i].data);
            @(negedge core_clk_i);
            `CHK(pad_oe[rows[i].port], rows[i].oe)
            `CHK(pad_pu[rows[i].port], rows[i].pu)
            `CHK(rd_data, rows[i].rd)
            `CHK(pad_out[rows[i].port] & pad_oe[rows[i].port], rows[i].out)
        end
        // Open-drain bits never carry a high drive value
        `CHK(pad_out[6][3:0], 4'h0)
        // Real-time transfers from both trigger sources
        wr(4'h0, SEL_RTOBUF, 8'hA5);
        `CHK(pad_out[8], 8'h00)
        pulse(tmr_req);
        `CHK(pad_out[8], 8'hA5)
        wr(4'h0, SEL_RTOBUF, 8'h3C);
        pulse(ext_req);
        `CHK(pad_out[8], 8'h3C)
        // A software latch write in the trigger cycle loses to the transfer
        @(negedge core_clk_i);
        {wr_en, wr_port, wr_sel, wr_data, tmr_req} = {1'b1, 4'h8, SEL_LATCH, 8'h00, 1'b1};
        @(negedge core_clk_i);
        {wr_en, tmr_req} = 2'b00;
        `CHK(pad_out[8], 8'h3C)
        // Earlier port 4 traffic left the flag set; start the edge test from clear
        pulse(edge_clr);
        `CHK(edge_flag, 1'b0)
        // Port 4 pins are pulled high; the board pulls one low
        ext_en[4] = 8'h10;
        repeat (3) @(negedge core_clk_i);
        `CHK(edge_flag, 1'b1)
        `CHK(test_req, 1'b1)
        edge_mask = 1'b1;
        repeat (2) @(negedge core_clk_i);
        `CHK(test_req, 1'b0)
        `CHK(edge_flag, 1'b1)
        pulse(edge_clr);
        @(negedge core_clk_i);
        `CHK(edge_flag, 1'b0)
        edge_mask = 1'b0;
        ext_en[4] = 8'h00;
        repeat (2) @(negedge core_clk_i);
        `CHK(edge_flag, 1'b0)
        ext_en[4] = 8'h80;
        repeat (3) @(negedge core_clk_i);
        `CHK(edge_flag, 1'b1)
        // A new edge in the clearing cycle wins over the clear
        pulse(edge_clr);
        `CHK(edge_flag, 1'b0)
        @(negedge core_clk_i);
        {edge_clr, ext_en[4]} = {1'b1, 8'h81};
        @(negedge core_clk_i);
        edge_clr = 1'b0;
        `CHK(edge_flag, 1'b1)
        // Watch timer source beside the port 4 source
        pulse(edge_clr);
        pulse(wt_ovf);
        @(negedge core_clk_i);
        `CHK({wt_flag, test_req}, 2'b11)
        wt_mask = 1'b1;
        repeat (2) @(negedge core_clk_i);
        `CHK(test_req, 1'b0)
        pulse(wt_clr);
        @(negedge core_clk_i);
        `CHK(wt_flag, 1'b0)
        // A reset in mid-run drops latches, directions and pull-ups back to idle
        @(negedge core_clk_i);
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        `CHK(pad_oe, pio_bytes_t'(0))
        `CHK(pad_pu[6], PU_FIXED_OPTION)
        `CHK(pad_pu[4], 8'h00)
        `CHK(pad_out[8], 8'h00)
        `CHK({edge_flag, wt_flag, test_req}, 3'h0)
        stop_test();
    end
endmodule
